// ### iop_core.sv
// pin function, power-down and reset logic behind an i2c register port
`include "iop_cfg.svh"

module iop_core #(
	parameter logic [6:0] DEV_ADDR  = `IOP_DEV_ADDR,
	parameter int         RESET_CYC = `IOP_RST_TIME_US * `IOP_CLK_MHZ
)(
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_n,
	input  wire logic                  hw_reset_n,
	input  wire logic [`IOP_NPIN-1:0]  pin_i,
	output logic      [`IOP_NPIN-1:0]  pin_o,
	output logic      [`IOP_NPIN-1:0]  pin_oe_n,
	output logic      [`IOP_NPIN-1:0]  pin_pulldown,
	output logic      [`IOP_NPIN-1:0]  dac_pd,
	output logic                       adc_pd,
	output logic                       ref_en,
	output iop_pkg::iop_mode_t         ptr_mode,
	output logic                       rst_busy
);
	import iop_pkg::*;

	localparam int CW = $clog2(RESET_CYC + 1);

	logic [`IOP_NPIN+2:0] sync_q;
	logic                 scl_d_r, sda_d_r, rstn_d_r;
	iop_state_t           st_r, st_nxt;
	logic [3:0]           bcnt_r, bcnt_nxt;
	logic [7:0]           sh_r, sh_nxt, ptr_r, ptr_nxt, msb_r, msb_nxt;
	logic [1:0]           bidx_r, bidx_nxt;
	logic                 rd_r, rd_nxt, txhi_r, txhi_nxt, sda_nxt;
	logic [15:0]          txw_r, txw_nxt, reg_rd;
	logic                 wr_fire, swrst_hit;
	logic [CW-1:0]        rst_cnt_r;
	logic [7:0]           pd_sel_r, out_sel_r, lvl_r, in_sel_r, od_r, ts_r;
	logic [7:0]           adc_cfg_r, dac_cfg_r;
	logic [15:0]          pdref_r, adc_seq_r;
	logic [7:0]           o_nxt, oe_n_nxt;

	// pins, scl, sda and the reset pin all come from outside the clock domain
	iop_sync #(
		.W       (`IOP_NPIN + 3),
		.RST_VAL ({3'h7, {`IOP_NPIN{1'b0}}})
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({hw_reset_n, scl_i, sda_i, pin_i}),
		.q    (sync_q)
	);

	wire       rstn_s = sync_q[`IOP_NPIN+2];
	wire       scl_s  = sync_q[`IOP_NPIN+1];
	wire       sda_s  = sync_q[`IOP_NPIN];
	wire [7:0] pin_s  = sync_q[`IOP_NPIN-1:0];

	// delayed copies give edges of the synchronised levels
	always_ff @(posedge clk) begin
		if (srst) begin
			{scl_d_r, sda_d_r, rstn_d_r} <= 3'h7;
		end else begin
			{scl_d_r, sda_d_r, rstn_d_r} <= {scl_s, sda_s, rstn_s};
		end
	end

	// bus events; start and stop are sda moves while scl stays high
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
	wire hw_fall   = rstn_d_r & ~rstn_s;
	wire do_reset  = swrst_hit | hw_fall;

	// pointer decode: high nibble is the mode, low nibble the register
	wire iop_mode_t mode = iop_mode_t'(ptr_r[7:4]);
	wire [15:0] wdata    = {msb_r, sh_r};
	wire        cfg_wr   = wr_fire & (mode == MD_CFG);
	wire        key_ok   = (mode == MD_CFG) && (ptr_r[3:0] == `IOP_OFS_SWRST) && ({msb_r, sh_r} == `IOP_SWRST_KEY);
	wire we_seq  = cfg_wr & (ptr_r[3:0] == `IOP_OFS_ADC_SEQ);
	wire we_adc  = cfg_wr & (ptr_r[3:0] == `IOP_OFS_ADC_CFG);
	wire we_dac  = cfg_wr & (ptr_r[3:0] == `IOP_OFS_DAC_CFG);
	wire we_pd   = cfg_wr & (ptr_r[3:0] == `IOP_OFS_PULLDN);
	wire we_osel = cfg_wr & (ptr_r[3:0] == `IOP_OFS_OUT_SEL);
	wire we_lvl  = cfg_wr & (ptr_r[3:0] == `IOP_OFS_OUT_LVL);
	wire we_isel = cfg_wr & (ptr_r[3:0] == `IOP_OFS_IN_SEL);
	wire we_ref  = cfg_wr & (ptr_r[3:0] == `IOP_OFS_PD_REF);
	wire we_od   = cfg_wr & (ptr_r[3:0] == `IOP_OFS_DRIVE);
	wire we_ts   = cfg_wr & (ptr_r[3:0] == `IOP_OFS_HIGHZ);

	// register readback; the write-only reset register reads zero
	always_comb begin
		case (ptr_r[3:0])
			`IOP_OFS_ADC_SEQ: reg_rd = adc_seq_r;
			`IOP_OFS_ADC_CFG: reg_rd = {8'h00, adc_cfg_r};
			`IOP_OFS_DAC_CFG: reg_rd = {8'h00, dac_cfg_r};
			`IOP_OFS_PULLDN:  reg_rd = {8'h00, pd_sel_r};
			`IOP_OFS_OUT_SEL: reg_rd = {8'h00, out_sel_r};
			`IOP_OFS_OUT_LVL: reg_rd = {8'h00, lvl_r};
			`IOP_OFS_IN_SEL:  reg_rd = {8'h00, in_sel_r};
			`IOP_OFS_PD_REF:  reg_rd = pdref_r;
			`IOP_OFS_DRIVE:   reg_rd = {8'h00, od_r};
			`IOP_OFS_HIGHZ:   reg_rd = {8'h00, ts_r};
			default:          reg_rd = 16'h0000;
		endcase
	end

	// input readback shows only pins selected as inputs, in the low byte
	wire [15:0] rd_word = (mode == MD_PIN_RD) ? {8'h00, pin_s & in_sel_r} :
	                      (mode == MD_REG_RD) ? reg_rd : 16'h0000;

	// byte engine: bits shift in on scl rise, sda changes only after scl fall
	always_comb begin
		st_nxt    = st_r;
		bcnt_nxt  = bcnt_r;
		sh_nxt    = sh_r;
		bidx_nxt  = bidx_r;
		rd_nxt    = rd_r;
		ptr_nxt   = ptr_r;
		msb_nxt   = msb_r;
		txw_nxt   = txw_r;
		txhi_nxt  = txhi_r;
		sda_nxt   = sda_oe_n;
		wr_fire   = 1'b0;
		swrst_hit = 1'b0;
		if (bus_start) begin
			st_nxt   = ST_RX;
			bcnt_nxt = 4'h0;
			bidx_nxt = 2'h0;
			sda_nxt  = 1'b1;
		end else if (bus_stop) begin
			st_nxt  = ST_IDLE;
			sda_nxt = 1'b1;
		end else begin
			case (st_r)
				ST_RX: begin
					if (scl_rise) begin
						sh_nxt   = {sh_r[6:0], sda_s};
						bcnt_nxt = bcnt_r + 4'h1;
					end else if (scl_fall && bcnt_r == 4'h8) begin
						st_nxt   = ST_ACK;
						sda_nxt  = 1'b0;
						bcnt_nxt = 4'h0;
						case (bidx_r)
							2'h0: begin
								rd_nxt   = sh_r[0];
								bidx_nxt = 2'h1;
								if (sh_r[7:1] != DEV_ADDR) begin
									st_nxt  = ST_IDLE;
									sda_nxt = 1'b1;
								end
							end
							2'h1: begin
								ptr_nxt  = sh_r;
								bidx_nxt = 2'h2;
							end
							2'h2: begin
								msb_nxt  = sh_r;
								bidx_nxt = 2'h3;
							end
							default: begin
								wr_fire  = 1'b1;
								bidx_nxt = 2'h2;
								if (key_ok) begin
									swrst_hit = 1'b1;
									st_nxt    = ST_IDLE;
									sda_nxt   = 1'b1;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall && rd_r) begin
						st_nxt   = ST_TX;
						txw_nxt  = rd_word;
						txhi_nxt = 1'b1;
						sh_nxt   = {rd_word[14:8], 1'b0};
						sda_nxt  = rd_word[15];
						bcnt_nxt = 4'h1;
					end else if (scl_fall) begin
						st_nxt  = ST_RX;
						sda_nxt = 1'b1;
					end
				end
				ST_TX: begin
					if (scl_fall && bcnt_r == 4'h8) begin
						st_nxt  = ST_MACK;
						sda_nxt = 1'b1;
					end else if (scl_fall) begin
						sda_nxt  = sh_r[7];
						sh_nxt   = {sh_r[6:0], 1'b0};
						bcnt_nxt = bcnt_r + 4'h1;
					end
				end
				ST_MACK: begin
					if (scl_rise && sda_s) begin
						st_nxt = ST_IDLE;
					end else if (scl_fall) begin
						st_nxt   = ST_TX;
						bcnt_nxt = 4'h1;
						txhi_nxt = ~txhi_r;
						if (txhi_r) begin
							sda_nxt = txw_r[7];
							sh_nxt  = {txw_r[6:0], 1'b0};
						end else begin
							txw_nxt = rd_word;
							sda_nxt = rd_word[15];
							sh_nxt  = {rd_word[14:8], 1'b0};
						end
					end
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
		// while a reset runs the bus is ignored, so a stray scl does no harm
		if (rst_busy | hw_fall) begin
			st_nxt  = ST_IDLE;
			sda_nxt = 1'b1;
		end
	end

	// byte engine state
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= ST_IDLE;
			{bcnt_r, sh_r, bidx_r, rd_r, ptr_r, msb_r, txw_r, txhi_r} <= '0;
		end else begin
			st_r <= st_nxt;
			{bcnt_r, sh_r, bidx_r, rd_r, ptr_r, msb_r, txw_r, txhi_r} <=
				{bcnt_nxt, sh_nxt, bidx_nxt, rd_nxt, ptr_nxt, msb_nxt, txw_nxt, txhi_nxt};
		end
	end

	// reset duration counter; the device stays deaf to scl until it ends
	wire [CW-1:0] rst_cnt_nxt = do_reset ? CW'(RESET_CYC) :
	                            (rst_cnt_r != '0) ? rst_cnt_r - 1'b1 : rst_cnt_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			rst_cnt_r <= '0;
			rst_busy  <= 1'b0;
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
			rst_busy  <= (rst_cnt_nxt != '0);
		end
	end

	// configuration registers; both resets restore the defaults
	always_ff @(posedge clk) begin
		if (srst | do_reset) begin
			pd_sel_r  <= `IOP_PULLDN_RST;
			{out_sel_r, lvl_r, in_sel_r, od_r, ts_r} <= '0;
			{adc_cfg_r, dac_cfg_r, pdref_r, adc_seq_r} <= '0;
		end else begin
			if (we_pd) pd_sel_r <= wdata[7:0];
			if (we_osel) out_sel_r <= wdata[7:0];
			if (we_isel) in_sel_r <= wdata[7:0];
			if (we_od) od_r <= wdata[7:0];
			if (we_ts) ts_r <= wdata[7:0];
			if (we_adc) adc_cfg_r <= wdata[7:0];
			if (we_dac) dac_cfg_r <= wdata[7:0];
			if (we_ref) pdref_r <= wdata;
			if (we_seq) adc_seq_r <= wdata;
			if (we_lvl) lvl_r <= (wdata[7:0] & out_sel_r) | (lvl_r & ~out_sel_r);
		end
	end

	// power decode; the dac value lives elsewhere and is never touched here
	wire       global_power_down  = pdref_r[`IOP_GLOBAL_POWER_DOWN_BIT];
	wire [7:0] dac_off = global_power_down ? '1 : pdref_r[7:0];
	wire       ref_on  = pdref_r[`IOP_EN_REF_BIT] & ~global_power_down;
	wire       adc_off = global_power_down | ((adc_cfg_r == 8'h00) & ~adc_seq_r[`IOP_TEMP_BIT]);

	// per-pin drive decision
	genvar gi;
	generate
		for (gi = 0; gi < `IOP_NPIN; gi++) begin : g_pin
			wire hz  = ts_r[gi] | (dac_cfg_r[gi] & dac_off[gi]);
			wire drv = out_sel_r[gi] & ~hz & (~od_r[gi] | ~lvl_r[gi]);
			assign oe_n_nxt[gi] = ~drv;
			assign o_nxt[gi]    = lvl_r[gi] & ~od_r[gi];
		end
	endgenerate

	// every output leaves through a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_o        <= '0;
			pin_oe_n     <= '1;
			pin_pulldown <= `IOP_PULLDN_RST;
			dac_pd       <= '0;
			adc_pd       <= 1'b1;
			ref_en       <= 1'b0;
			ptr_mode     <= MD_CFG;
			sda_oe_n     <= 1'b1;
			sda_o        <= 1'b0;
		end else begin
			pin_o        <= o_nxt;
			pin_oe_n     <= oe_n_nxt;
			pin_pulldown <= pd_sel_r;
			dac_pd       <= dac_cfg_r & dac_off;
			adc_pd       <= adc_off;
			ref_en       <= ref_on;
			ptr_mode     <= mode;
			sda_oe_n     <= sda_nxt;
			sda_o        <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	swrst_nack_a: assert property (swrst_hit |=> sda_oe_n [*3])
		else $error("soft reset byte was acknowledged");
	swrst_dflt_a: assert property (swrst_hit |-> ##2 (pin_pulldown == `IOP_PULLDN_RST) && pin_oe_n == '1)
		else $error("soft reset did not restore pin defaults");
	hwrst_dflt_a: assert property (hw_fall |-> ##2 pin_pulldown == `IOP_PULLDN_RST && !ref_en)
		else $error("reset pin edge did not restore defaults");
	ref_off_a: assert property ($fell(rst_busy) |-> !ref_en)
		else $error("reference enabled right after reset");
	highz_pin_a: assert property ((~pin_oe_n & $past(ts_r)) == '0)
		else $error("high-z pin is driven");
	gpo_only_a: assert property ((~pin_oe_n & ~$past(out_sel_r)) == '0)
		else $error("non-output pin is driven");
	od_low_a: assert property ((~pin_oe_n & $past(od_r) & pin_o) == '0)
		else $error("open-drain pin driven high");
	pp_level_a: assert property (((pin_o ^ $past(lvl_r)) & ~pin_oe_n & ~$past(od_r)) == '0)
		else $error("push-pull pin level wrong");
	global_power_down_a: assert property ($past(global_power_down) |-> adc_pd && !ref_en && dac_pd == $past(dac_cfg_r))
		else $error("global power-down not applied");
	adc_auto_a: assert property ($past(adc_cfg_r == 8'h00 && !adc_seq_r[`IOP_TEMP_BIT]) |-> adc_pd)
		else $error("adc powered without adc pins");
	lvl_mask_a: assert property (we_lvl |=> (lvl_r & ~$past(out_sel_r)) == ($past(lvl_r) & ~$past(out_sel_r)))
		else $error("level bit of non-output pin changed");
endmodule

// ### iop_cfg.svh
// offsets, field positions, reset values and timing counts of the pin block
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH
`define IOP_NPIN        8
`define IOP_OFS_ADC_SEQ 4'h2
`define IOP_OFS_ADC_CFG 4'h4
`define IOP_OFS_DAC_CFG 4'h5
`define IOP_OFS_PULLDN  4'h6
`define IOP_OFS_OUT_SEL 4'h8
`define IOP_OFS_OUT_LVL 4'h9
`define IOP_OFS_IN_SEL  4'ha
`define IOP_OFS_PD_REF  4'hb
`define IOP_OFS_DRIVE   4'hc
`define IOP_OFS_HIGHZ   4'hd
`define IOP_OFS_SWRST   4'hf
`define IOP_SWRST_KEY   16'h0dac
`define IOP_PULLDN_RST  8'hff
`define IOP_TEMP_BIT    8
`define IOP_EN_REF_BIT  9
`define IOP_GLOBAL_POWER_DOWN_BIT  10
`define IOP_DEV_ADDR    7'h10
`define IOP_RST_TIME_US 250
`define IOP_CLK_MHZ     100
`endif

// ### iop_pkg.sv
// types shared by the pin block files
package iop_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} iop_state_t;
	typedef enum logic [3:0] {
		MD_CFG    = 4'h0,
		MD_DAC_WR = 4'h1,
		MD_ADC_RD = 4'h4,
		MD_DAC_RD = 4'h5,
		MD_PIN_RD = 4'h6,
		MD_REG_RD = 4'h7
	} iop_mode_t;
endpackage

// ### iop_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
module iop_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ### iop_host_model.sv
// i2c controller model that drives the pin block's register port
module iop_host_model #(
	parameter logic [6:0] ADDR = 7'h10
)(
	input  wire logic clk,
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_out = 1'b1;
	end
	// a quarter of the 160 ns scl period
	task automatic q();
		repeat (4) @(posedge clk);
	endtask
	task automatic start();
		q();
		sda_out <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic stop();
		sda_out <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_out <= 1'b1;
		q();
	endtask
	// data moves only while scl is low; the line is sampled mid-high
	task automatic clock_bit(input logic b, output logic s);
		sda_out <= b;
		q();
		scl <= 1'b1;
		q();
		s = sda_in;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(b[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(1'b1, b[i]);
		clock_bit(last, s);
	endtask
	// four-byte write, or pointer only when words is low
	task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d, input logic words, output logic ack);
		logic a;
		start();
		send_byte({ADDR, 1'b0}, a);
		send_byte(ptr, a);
		if (words) begin
			send_byte(d[15:8], a);
			send_byte(d[7:0], a);
		end
		ack = a;
		stop();
	endtask
	// set the pointer, then read one word and refuse more
	task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
		logic a;
		write_reg(ptr, 16'h0000, 1'b0, a);
		start();
		send_byte({ADDR, 1'b1}, a);
		get_byte(1'b0, d[15:8]);
		get_byte(1'b1, d[7:0]);
		stop();
	endtask
endmodule

// ### iop_core_test.sv
// self-checking bench for the pin block behind its i2c port
module iop_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import iop_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       hw_reset_n = 1'b1;
	logic [7:0] pin_i = 8'h00;
	logic       scl, host_sda, sda_o, sda_oe_n, adc_pd, ref_en, rst_busy;
	logic [7:0] pin_o, pin_oe_n, pin_pulldown, dac_pd;
	iop_mode_t  ptr_mode;
	int         n_errors = 0;
	int         tests_run = 0;
	integer     seed = 83031;
	logic [3:0] modes [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7};
	// open-drain bus with a pull-up: either party can only pull low
	wire        sda = host_sda & (sda_oe_n | sda_o);
	always #5 clk = ~clk;
	iop_core #(.RESET_CYC(100)) u_iop_core (.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .hw_reset_n(hw_reset_n), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.pin_pulldown(pin_pulldown), .dac_pd(dac_pd), .adc_pd(adc_pd), .ref_en(ref_en),
		.ptr_mode(ptr_mode), .rst_busy(rst_busy));
	iop_host_model u_iop_host_model (.clk(clk), .sda_in(sda), .scl(scl), .sda_out(host_sda));
	task automatic results();
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
		logic a;
		u_iop_host_model.write_reg(ptr, d, 1'b1, a);
		repeat (4) @(posedge clk);
	endtask
	// a pin is driven only as a selected, unfloated output not idling high in open drain
	function automatic logic [7:0] exp_oe_n(input logic [7:0] sel, hz, od, lvl);
		return ~(sel & ~hz & ~(od & lvl));
	endfunction
	// the defaults that both reset paths must restore
	task automatic chk_defaults();
		chk({pin_pulldown, pin_oe_n}, 16'hffff, "pin defaults");
		chk({6'h00, dac_pd, ref_en, adc_pd}, 16'h0001, "power defaults");
	endtask
	initial begin
		#1_000_000;
		n_errors++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		results();
	end
	initial begin
		logic [7:0]  sel, lvl, od, hz, ins, pv, dm, pd, lvl_m, e;
		logic [15:0] rd;
		logic        a;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk_defaults();
		lvl_m = 8'h00;
		// random pin setups, the first round with every pin an output
		for (int r = 0; r < 4; r++) begin
			sel = (r == 0) ? 8'hff : 8'($random(seed));
			od = (r == 0) ? 8'h00 : 8'($random(seed));
			hz = (r < 2) ? 8'h00 : 8'($random(seed));
			lvl = 8'($random(seed));
			wr(8'h08, {8'h00, sel});
			wr(8'h0c, {8'h00, od});
			wr(8'h0d, {8'h00, hz});
			wr(8'h09, {8'h00, lvl});
			e = exp_oe_n(sel, hz, od, lvl);
			// level bits of non-output pins keep what an earlier round left there
			lvl_m = (lvl & sel) | (lvl_m & ~sel);
			chk({8'h00, pin_oe_n}, {8'h00, e}, "drive enables");
			chk({8'h00, pin_o & ~e}, {8'h00, lvl & ~e}, "pin levels");
			u_iop_host_model.read_reg(8'h79, rd);
			chk(rd, {8'h00, lvl_m}, "level readback");
			pd = 8'($random(seed));
			wr(8'h06, {8'h00, pd});
			chk({8'h00, pin_pulldown}, {8'h00, pd}, "pull-downs");
			ins = 8'($random(seed));
			pv = 8'($random(seed));
			wr(8'h0a, {8'h00, ins});
			pin_i <= pv;
			u_iop_host_model.read_reg(8'h60, rd);
			chk(rd, {8'h00, pv & ins}, "input readback");
		end
		foreach (modes[i]) begin
			u_iop_host_model.write_reg({modes[i], 4'h0}, 16'h0000, 1'b0, a);
			chk({12'h000, ptr_mode}, {12'h000, modes[i]}, "pointer mode");
		end
		// an offset outside the block keeps nothing
		wr(8'h07, 16'h00ff);
		u_iop_host_model.read_reg(8'h77, rd);
		chk(rd, 16'h0000, "unmapped offset");
		dm = 8'($random(seed)) | 8'h01;
		pd = 8'($random(seed));
		wr(8'h05, {8'h00, dm});
		wr(8'h0b, {8'h02, pd});
		chk({7'h00, dac_pd, ref_en}, {7'h00, dm & pd, 1'b1}, "dac down, ref on");
		wr(8'h04, 16'h0002);
		chk({15'h0000, adc_pd}, 16'h0000, "adc up with a pin");
		wr(8'h0b, {8'h06, pd});
		chk({6'h00, dac_pd, ref_en, adc_pd}, {6'h00, dm, 2'b01}, "global power-down");
		wr(8'h0b, 16'h0000);
		chk({8'h00, dac_pd}, 16'h0000, "dacs back up");
		wr(8'h04, 16'h0000);
		chk({15'h0000, adc_pd}, 16'h0001, "adc down, no pins");
		wr(8'h02, 16'h0100);
		chk({15'h0000, adc_pd}, 16'h0000, "adc up for temperature");
		u_iop_host_model.write_reg(8'h0f, 16'h0dac, 1'b1, a);
		chk({14'h0000, a, rst_busy}, 16'h0001, "soft reset unacked");
		// the controller stays silent while the reset runs
		repeat (150) @(posedge clk);
		chk_defaults();
		u_iop_host_model.read_reg(8'h7b, rd);
		chk(rd, 16'h0000, "power register cleared");
		wr(8'h06, 16'h0000);
		wr(8'h0b, 16'h0200);
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({15'h0000, rst_busy}, 16'h0001, "pin reset busy");
		hw_reset_n <= 1'b1;
		repeat (150) @(posedge clk);
		chk_defaults();
		results();
	end
endmodule
